// ===== rtl/abg_pkg.sv
package abg_pkg;

  // Bus clock period.
  localparam int unsigned CLK_PERIOD_NS = 25;

  // The board answers on eight ports starting at 200 octal.
  localparam logic [7:0] BOARD_BASE     = 8'h80;
  localparam int unsigned BOARD_SPAN_LSB = 3;
  localparam logic [2:0] CHAN_PORT_OFS  = 3'h1;
  localparam logic [2:0] DATA_PORT_OFS  = 3'h4;

  // Pulse lengths in nanoseconds and the derived cycle counts.
  localparam int unsigned ENABLE_NS  = 500;
  localparam int unsigned START_NS   = 150;
  localparam int unsigned ENABLE_CYC = (ENABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned START_CYC  = (START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W      = 5;

  // Channel number layout: three bits within a group, two bits of group.
  localparam int unsigned CHAN_W     = 5;
  localparam int unsigned GROUP_LSB  = 3;
  localparam int unsigned GROUPS     = 3;

  // Reset values.
  localparam logic [4:0] CHAN_RESET = 5'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Access sequencer states, one-hot.
  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'h1,
    ST_WRITE = 3'h2,
    ST_READ  = 3'h4
  } abg_state_e;

endpackage : abg_pkg

// ===== rtl/abg_pulse.sv
// Stretches a one-cycle trigger into a high pulse of a fixed number of cycles.
// The output comes straight from a flip-flop; a new trigger restarts the count.
module abg_pulse #(
  parameter logic [4:0] LENGTH = 5'h01
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // Trigger and pulse
  input  wire logic trigger,
  output logic      pulse_q
);

  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic       pulse_d;

  always_comb
  begin
    cnt_d   = cnt_q;
    pulse_d = pulse_q;
    if (trigger)
    begin
      cnt_d   = LENGTH - 5'h01;
      pulse_d = 1'b1;
    end
    else if (cnt_q != 5'h00)
    begin
      cnt_d = cnt_q - 5'h01;
    end
    else
    begin
      pulse_d = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q   <= 5'h00;
      pulse_q <= 1'b0;
    end
    else
    begin
      cnt_q   <= cnt_d;
      pulse_q <= pulse_d;
    end
  end

endmodule : abg_pulse

// ===== rtl/abg_bus_glue.sv
// Behaviour
// - On a board write, the written byte appears on both adapters' data lines.
// - Every adapter data bit follows its own written bit independently.
// - On a board read, adapter data pass uninverted onto the bus input lines.
// - Every board read or write gives a 500 ns high adapter enable pulse.
// - Every board write gives a 500 ns low wait request to the host.
// - Eight-channel select lines carry the complement of the channel; MSB first.
// - Group select lines carry the complemented in-group channel, MSB first.
// - Every board read starts a converter start pulse of about 150 ns.
// - At most one group multiplexer is enabled, active low, by channel group; group 3 enables none.
module abg_bus_glue (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Host processor input and output cycles
  input  wire logic [7:0] io_addr,
  input  wire logic [7:0] io_wdata,
  input  wire logic       io_wr,
  input  wire logic       io_rd,
  output logic      [7:0] bus_input_lines_q,
  output logic            wait_req_n_q,
  // Peripheral adapter side
  input  wire logic [7:0] adapter_data_i,
  output logic      [7:0] adapter_data_o_q,
  output logic            adapter_data_oe_q,
  output logic            adapter_enable_q,
  output logic            write_strobe_node_n_q,
  output logic            read_strobe_node_n_q,
  // Converter and multiplexers
  output logic            converter_start_q,
  output logic      [2:0] chan8_sel_n_q,
  output logic      [2:0] group_sel_n_q,
  output logic      [2:0] group_en_n_q
);

  localparam logic [4:0] ENABLE_LEN = 5'(abg_pkg::ENABLE_CYC);
  localparam logic [4:0] START_LEN  = 5'(abg_pkg::START_CYC);

  // True when a port address falls in the board's eight-port window.
  function automatic logic board_hit(input logic [7:0] addr);
    board_hit = addr[7:abg_pkg::BOARD_SPAN_LSB] ==
                abg_pkg::BOARD_BASE[7:abg_pkg::BOARD_SPAN_LSB];
  endfunction : board_hit

  abg_pkg::abg_state_e state_q;
  abg_pkg::abg_state_e state_d;
  logic [4:0]          cnt_q;
  logic [4:0]          cnt_d;
  logic                access_q;
  logic                access_now;
  logic                start_wr;
  logic                start_rd;
  logic                conv_trigger;

  logic [7:0]          data_o_d;
  logic                data_oe_d;
  logic                enable_d;
  logic                wait_n_d;
  logic                wr_node_n_d;
  logic                rd_node_n_d;
  logic [7:0]          bus_in_d;

  logic [4:0]          chan_q;
  logic [4:0]          chan_d;
  logic [2:0]          chan8_d;
  logic [2:0]          gsel_d;
  logic [2:0]          gen_d;

  // A cycle starts on the first clock its strobe is seen, so a strobe that the
  // host holds for many clocks produces one access, not a train of them.
  assign access_now = board_hit(io_addr) && (io_wr || io_rd);
  assign start_wr   = access_now && !access_q && io_wr;
  assign start_rd   = access_now && !access_q && !io_wr && io_rd;

  // Access sequencer.
  always_comb
  begin
    state_d      = state_q;
    cnt_d        = cnt_q;
    data_o_d     = adapter_data_o_q;
    data_oe_d    = adapter_data_oe_q;
    enable_d     = adapter_enable_q;
    wait_n_d     = wait_req_n_q;
    wr_node_n_d  = write_strobe_node_n_q;
    rd_node_n_d  = read_strobe_node_n_q;
    bus_in_d     = bus_input_lines_q;
    conv_trigger = 1'b0;
    case (state_q)
      abg_pkg::ST_IDLE:
      begin
        if (start_wr)
        begin
          state_d     = abg_pkg::ST_WRITE;
          cnt_d       = ENABLE_LEN - 5'h01;
          data_o_d    = io_wdata;
          data_oe_d   = 1'b1;
          wr_node_n_d = 1'b0;
          enable_d    = 1'b1;
          wait_n_d    = 1'b0;
        end
        else if (start_rd)
        begin
          state_d      = abg_pkg::ST_READ;
          cnt_d        = ENABLE_LEN - 5'h01;
          rd_node_n_d  = 1'b0;
          enable_d     = 1'b1;
          conv_trigger = 1'b1;
        end
      end
      abg_pkg::ST_WRITE:
      begin
        if (cnt_q == 5'h00)
        begin
          // Wait and enable drop together so the host cannot finish early.
          state_d     = abg_pkg::ST_IDLE;
          enable_d    = 1'b0;
          wait_n_d    = 1'b1;
          wr_node_n_d = 1'b1;
          data_oe_d   = 1'b0;
        end
        else
        begin
          cnt_d = cnt_q - 5'h01;
        end
      end
      abg_pkg::ST_READ:
      begin
        // Adapter data are sampled every clock of the read; no inversion.
        bus_in_d = adapter_data_i;
        if (cnt_q == 5'h00)
        begin
          state_d     = abg_pkg::ST_IDLE;
          enable_d    = 1'b0;
          rd_node_n_d = 1'b1;
        end
        else
        begin
          cnt_d = cnt_q - 5'h01;
        end
      end
      default:
      begin
        state_d     = abg_pkg::ST_IDLE;
        cnt_d       = 5'h00;
        enable_d    = 1'b0;
        wait_n_d    = 1'b1;
        wr_node_n_d = 1'b1;
        rd_node_n_d = 1'b1;
        data_oe_d   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_q               <= abg_pkg::ST_IDLE;
      cnt_q                 <= 5'h00;
      access_q              <= 1'b0;
      adapter_data_o_q      <= abg_pkg::BYTE_RESET;
      adapter_data_oe_q     <= 1'b0;
      adapter_enable_q      <= 1'b0;
      wait_req_n_q          <= 1'b1;
      write_strobe_node_n_q <= 1'b1;
      read_strobe_node_n_q  <= 1'b1;
      bus_input_lines_q     <= abg_pkg::BYTE_RESET;
    end
    else
    begin
      state_q               <= state_d;
      cnt_q                 <= cnt_d;
      access_q              <= access_now;
      adapter_data_o_q      <= data_o_d;
      adapter_data_oe_q     <= data_oe_d;
      adapter_enable_q      <= enable_d;
      wait_req_n_q          <= wait_n_d;
      write_strobe_node_n_q <= wr_node_n_d;
      read_strobe_node_n_q  <= rd_node_n_d;
      bus_input_lines_q     <= bus_in_d;
    end
  end

  // Channel latch and multiplexer selects. Channels above 23 leave every
  // group disabled, which keeps a bad channel number off the converter.
  always_comb
  begin
    chan_d = chan_q;
    // A channel write that lands while an access still runs is refused, like
    // the access itself, so the selects never move under a running conversion.
    if (start_wr && (state_q == abg_pkg::ST_IDLE) &&
        (io_addr[2:0] == abg_pkg::CHAN_PORT_OFS))
    begin
      chan_d = io_wdata[abg_pkg::CHAN_W-1:0];
    end
    chan8_d = ~{chan_d[2], chan_d[1], chan_d[0]};
    gsel_d  = ~{chan_d[2], chan_d[1], chan_d[0]};
    gen_d   = 3'h7;
    case (chan_d[4:abg_pkg::GROUP_LSB])
      2'h0:    gen_d = 3'h6;
      2'h1:    gen_d = 3'h5;
      2'h2:    gen_d = 3'h3;
      default: gen_d = 3'h7;
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      chan_q        <= abg_pkg::CHAN_RESET;
      chan8_sel_n_q <= 3'h7;
      group_sel_n_q <= 3'h7;
      group_en_n_q  <= 3'h6;
    end
    else
    begin
      chan_q        <= chan_d;
      chan8_sel_n_q <= chan8_d;
      group_sel_n_q <= gsel_d;
      group_en_n_q  <= gen_d;
    end
  end

  // Converter start on every board read.
  abg_pulse #(
    .LENGTH (START_LEN)
  ) u_conv_start (
    .mclk    (mclk),
    .rst     (rst),
    .trigger (conv_trigger),
    .pulse_q (converter_start_q)
  );

endmodule : abg_bus_glue

// ===== sim/abg_adapter_model.sv
// Two adapters on the far side: they drive the read value only while the read
// strobe is low; otherwise the lines toggle so a stale value cannot pass.
module abg_adapter_model (
  input  wire logic       mclk,
  input  wire logic       rd_n,
  input  wire logic [7:0] value,
  output logic      [7:0] data = 8'h5A
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge mclk)
  begin
    data <= rd_n ? ~data : value;
  end
endmodule : abg_adapter_model

// ===== sim/abg_bus_glue_checker.sv
module abg_bus_glue_checker (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic       io_wr,
  input wire logic       io_rd,
  input wire logic       wait_req_n_q,
  input wire logic [7:0] adapter_data_o_q,
  input wire logic       adapter_enable_q,
  input wire logic       write_strobe_node_n_q,
  input wire logic       read_strobe_node_n_q,
  input wire logic       converter_start_q,
  input wire logic [2:0] chan8_sel_n_q,
  input wire logic [2:0] group_sel_n_q,
  input wire logic [2:0] group_en_n_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire logic hit = io_addr[7:3] == 5'h10 && (io_wr || io_rd);
  sequence chw;
    $fell(write_strobe_node_n_q) && $past(io_addr[2:0]) == 3'h1;
  endsequence
  start_en_a: assert property ($rose(hit) && !adapter_enable_q |=> adapter_enable_q)
    else $error("board access raised no enable");
  en_len_a: assert property ($rose(adapter_enable_q) |-> ##19 adapter_enable_q ##1 !adapter_enable_q)
    else $error("enable length wrong");
  wait_len_a: assert property ($fell(wait_req_n_q) |-> ##19 !wait_req_n_q ##1 wait_req_n_q)
    else $error("wait length wrong");
  wait_en_a: assert property (!wait_req_n_q |-> adapter_enable_q && !write_strobe_node_n_q)
    else $error("wait outside a write access");
  start_len_a: assert property ($rose(converter_start_q) |->
    !read_strobe_node_n_q ##5 converter_start_q ##1 !converter_start_q)
    else $error("start pulse length wrong");
  rd_start_a: assert property ($fell(read_strobe_node_n_q) |-> converter_start_q)
    else $error("read gave no start pulse");
  wr_data_a: assert property ($fell(write_strobe_node_n_q) |-> adapter_data_o_q == $past(io_wdata))
    else $error("written byte not on adapter lines");
  sel_match_a: assert property (group_sel_n_q == chan8_sel_n_q)
    else $error("group select differs");
  chan_sel_a: assert property (chw |-> chan8_sel_n_q == ~$past(io_wdata[2:0]))
    else $error("channel select wrong");
  group_en_a: assert property (chw |-> group_en_n_q == (
    $past(io_wdata[4:3]) == 2'h3 ? 3'h7 : ~(3'h1 << $past(io_wdata[4:3]))))
    else $error("group enable wrong");
  cover property ($fell(write_strobe_node_n_q));
  cover property ($rose(converter_start_q));
  cover property (group_en_n_q == 3'h7);
endmodule : abg_bus_glue_checker
bind abg_bus_glue abg_bus_glue_checker u_chk (.mclk, .rst, .io_addr, .io_wdata, .io_wr,
  .io_rd, .wait_req_n_q, .adapter_data_o_q, .adapter_enable_q, .write_strobe_node_n_q,
  .read_strobe_node_n_q, .converter_start_q, .chan8_sel_n_q, .group_sel_n_q, .group_en_n_q);

// ===== sim/abg_bus_glue_tb_top.sv
module abg_bus_glue_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  io_addr = 8'h00;
  logic [7:0]  io_wdata = 8'h00;
  logic        io_wr = 1'b0;
  logic        io_rd = 1'b0;
  logic [7:0]  pv = 8'h00;
  logic [7:0]  bus_in, ad_i, ad_o;
  logic        wt_n, en, rn, cs, oe, wn;
  logic [2:0]  c8, gs, ge;
  logic [31:0] rs = 32'h496356FB;
  int          err_count = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          ch = 0;
  always #12.5 mclk = ~mclk;
  abg_bus_glue dut (.mclk, .rst, .io_addr, .io_wdata, .io_wr, .io_rd,
    .bus_input_lines_q(bus_in), .wait_req_n_q(wt_n), .adapter_data_i(ad_i),
    .adapter_data_o_q(ad_o), .adapter_data_oe_q(oe), .adapter_enable_q(en),
    .write_strobe_node_n_q(wn), .read_strobe_node_n_q(rn), .converter_start_q(cs),
    .chan8_sel_n_q(c8), .group_sel_n_q(gs), .group_en_n_q(ge));
  abg_adapter_model u_pm (.mclk, .rd_n(rn), .value(pv), .data(ad_i));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  task automatic chk8(input logic [7:0] g, e);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk8
  task automatic chkc(input int g, e);
    tests_run++;
    if (g != e)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chkc
  // The strobe is held past the access, so a retrigger would show as extra counts.
  task automatic acc(input bit w, input logic [7:0] a, d, input int hit);
    int e = 0, t = 0, s = 0, o = 0;
    io_wr = w;
    io_rd = !w;
    io_addr = a;
    io_wdata = d;
    repeat (26)
    begin
      @(negedge mclk);
      e += int'(en === 1'b1);
      t += int'(wt_n === 1'b0);
      s += int'(cs === 1'b1);
      o += int'(w ? (oe === 1'b1 && wn === 1'b0) : (rn === 1'b0));
    end
    io_wr = 1'b0;
    io_rd = 1'b0;
    @(negedge mclk);
    chkc(e, hit * 20);
    chkc(t, hit * w * 20);
    chkc(s, hit * (1 - w) * 6);
    chkc(o, hit * 20);
  endtask : acc
  task automatic sel;
    chk8(c8, 8'(7 - ch % 8));
    chk8(gs, 8'(7 - ch % 8));
    chk8(ge, ch > 23 ? 8'h07 : 8'(7 - (1 << ch / 8)));
  endtask : sel
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      conclude();
    end
  end
  initial
  begin
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    sel();
    for (int i = 0; i < 32; i++)
    begin
      rs = xs(rs);
      acc(1, 8'h81, {rs[7:5], 5'(i)}, 1);
      ch = i;
      chk8(ad_o, {rs[7:5], 5'(i)});
      sel();
    end
    $display("test channel select done");
    for (int i = 0; i < 8; i++)
    begin
      acc(1, 8'h82, 8'h01 << i, 1);
      chk8(ad_o, 8'h01 << i);
      sel();
    end
    $display("test output bits done");
    for (int i = 0; i < 12; i++)
    begin
      rs = xs(rs);
      pv = i < 8 ? ~(8'h01 << i) : rs[15:8];
      acc(0, 8'h84, 8'h00, 1);
      chk8(bus_in, pv);
    end
    $display("test input bits done");
    acc(1, 8'h00, 8'hFF, 0);
    acc(0, 8'h88, 8'h00, 0);
    chk8(ad_o, 8'h80);
    $display("test off board done");
    conclude();
  end
endmodule : abg_bus_glue_tb_top
